// *** bench/ldc_master.sv ***
/*
 * Model of the external controller that runs the three-wire register link.
 * Assumes the shared data line has a pull-up and the device only pulls it low.
 */
module ldc_master (
	input wire logic mclk,
	input wire logic sda_out,
	input wire logic sda_oe_n,
	output logic chip_select,
	output logic scl,
	output logic sda_in
);
	timeunit 1ns;
	timeprecision 100ps;
	logic m_en = 1'b0;
	logic m_bit = 1'b1;

	initial begin
		chip_select = 1'b0;
		scl = 1'b0;
	end

	// Either side may pull the line low; the pull-up wins otherwise.
	assign sda_in = (m_en ? m_bit : 1'b1) & (sda_oe_n ? 1'b1 : sda_out);

	// The clock stands low outside frames and the line is released after a set read flag.
	task automatic frame(input logic [6:0] addr, input logic rw, input logic [7:0] wd,
		output logic [7:0] rd);
		logic [15:0] word;
		word = {addr, rw, wd};
		rd = 8'h00;
		chip_select = 1'b1;
		repeat (2) @(negedge mclk);
		for (int i = 15; i >= 0; i--) begin
			m_en = !(rw && i < 8);
			m_bit = word[i];
			repeat (3) @(negedge mclk);
			scl = 1'b1;
			repeat (3) @(negedge mclk);
			scl = 1'b0;
			if (i < 8)
				rd[i] = sda_in;
		end
		repeat (2) @(negedge mclk);
		chip_select = 1'b0;
		m_en = 1'b0;
		@(negedge mclk);
	endtask : frame
endmodule : ldc_master

// *** bench/tb_top.sv ***
/*
 * Self-checking bench for the laser driver control block, driven over its serial link.
 * Assumes the controller model in ldc_master and the register map of ldc_pkg.
 */
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import ldc_pkg::*;
	localparam logic [1:0] ADDR_HI = 2'h2;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic [1:0] alsel = ADDR_HI;
	logic disable_in = 1'b0;
	logic dpos = 1'b1;
	logic dneg = 1'b0;
	logic sig_det = 1'b0;
	logic [3:0] hard_src = 4'h0;
	logic [3:0] soft_src = 4'h0;
	logic cs, scl, sda_in, sda_out, sda_oe_n, anode, cathode, fault;
	logic [8:0] bias_dac, mod_dac;
	logic [1:0] eq_boost, deemph_range, addr_hi;
	logic [7:0] deemph_level;
	int bad_count = 0;
	int comparisons = 0;

`define CHK(got, exp) begin \
	comparisons++; \
	if ((got) !== (exp)) begin \
		bad_count++; \
		$display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); \
	end \
end

	always #5 mclk = ~mclk;

	ldc_master master (.mclk(mclk), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.chip_select(cs), .scl(scl), .sda_in(sda_in));

	ldc_core dut (.mclk(mclk), .sys_rst(sys_rst), .chip_select(cs), .scl(scl),
		.sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.address_level_select(alsel), .disable_in(disable_in), .data_in_pos(dpos),
		.data_in_neg(dneg), .signal_detect(sig_det), .hard_fault_src(hard_src),
		.soft_fault_src(soft_src), .laser_anode_out(anode), .laser_cathode_out(cathode),
		.bias_dac(bias_dac), .mod_dac(mod_dac), .eq_boost(eq_boost),
		.deemph_range(deemph_range), .deemph_level(deemph_level), .addr_hi(addr_hi),
		.fault(fault));

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish

	task automatic do_reset;
		sys_rst = 1'b1;
		repeat (3) @(negedge mclk);
		sys_rst = 1'b0;
		repeat (2) @(negedge mclk);
	endtask : do_reset

	task automatic wr(input logic [4:0] ofs, input logic [7:0] d);
		logic [7:0] rd;
		master.frame({ADDR_HI, ofs}, 1'b0, d, rd);
		repeat (3) @(negedge mclk);
	endtask : wr

	task automatic rd_chk(input logic [4:0] ofs, input logic [7:0] exp);
		logic [7:0] rd;
		master.frame({ADDR_HI, ofs}, 1'b1, 8'h00, rd);
		`CHK(rd, exp)
	endtask : rd_chk

	task automatic pause;
		repeat (3) @(negedge mclk);
	endtask : pause

	task automatic clear_latch;
		disable_in = 1'b1;
		repeat (2) @(negedge mclk);
		disable_in = 1'b0;
		pause();
	endtask : clear_latch

	// The controller adjusts codes through the step registers once set up.
	task automatic chan(input logic [4:0] c_ofs, input logic [4:0] l_ofs,
		input logic [4:0] s_ofs, input logic [7:0] warn, input logic m);
		clear_latch();
		wr(c_ofs, 8'h10);
		wr(s_ofs, 8'h85);
		`CHK(m ? mod_dac : bias_dac, 9'h02B)
		wr(s_ofs, 8'h1B);
		rd_chk(c_ofs, 8'h10);
		repeat (2) wr(s_ofs, 8'h10);
		rd_chk(c_ofs, 8'h00);
		wr(l_ofs, 8'h20);
		wr(c_ofs, 8'h1E);
		rd_chk(OFS_SOFT_FAULT_STATUS, 8'h00);
		wr(s_ofs, 8'h0F);
		rd_chk(c_ofs, 8'h20);
		rd_chk(OFS_SOFT_FAULT_STATUS, warn);
		wr(c_ofs, 8'h30);
		`CHK(m ? mod_dac : bias_dac, 9'h040)
		wr(l_ofs, RST_LIMIT);
		`CHK(m ? mod_dac : bias_dac, 9'h060)
	endtask : chan

	initial begin
		logic [7:0] rd;
		for (int l = 0; l < 4; l++) begin
			alsel = 2'(l);
			do_reset();
			`CHK(addr_hi, 2'(l))
		end
		alsel = ADDR_HI;
		do_reset();
		`CHK(bias_dac, DAC_OFF)
		rd_chk(OFS_TRANSMIT_CONTROL, RST_CTRL);
		rd_chk(OFS_BIAS_CODE, RST_CODE);
		rd_chk(OFS_MODULATION_CODE_LIMIT, RST_LIMIT);
		rd_chk(OFS_BIAS_STEP, RST_ZERO);
		$display("test reset done");
		for (int e = 0; e < 4; e++) begin
			if (e != 2) begin
				wr(OFS_INPUT_EQ_SETTING, 8'(e));
				`CHK(eq_boost, 2'(e))
			end
		end
		wr(OFS_TRANSMIT_CONTROL, 8'h18);
		wr(OFS_DEEMPHASIS_SETTING, 8'h5A);
		`CHK({deemph_range, deemph_level}, 10'h35A)
		$display("test settings done");
		wr(OFS_TRANSMIT_CONTROL, 8'h01);
		`CHK({bias_dac, mod_dac}, 18'h01008)
		`CHK({anode, cathode}, 2'b01)
		wr(OFS_TRANSMIT_CONTROL, 8'h03);
		`CHK({anode, cathode}, 2'b10)
		wr(OFS_TRANSMIT_CONTROL, 8'h01);
		$display("test enable done");
		chan(OFS_BIAS_CODE, OFS_BIAS_CODE_LIMIT, OFS_BIAS_STEP, 8'h01, 1'b0);
		chan(OFS_MODULATION_CODE, OFS_MODULATION_CODE_LIMIT, OFS_MODULATION_STEP, 8'h02, 1'b1);
		$display("test stepping done");
		clear_latch();
		sig_det = 1'b1;
		rd_chk(OFS_HARD_FAULT_STATUS, 8'h20);
		sig_det = 1'b0;
		wr(OFS_FAULT_MASK, 8'h01);
		hard_src = 4'h1;
		pause();
		`CHK({fault, bias_dac}, 10'h060)
		rd_chk(OFS_HARD_FAULT_STATUS, 8'h00);
		hard_src = 4'h2;
		pause();
		`CHK({fault, bias_dac, mod_dac, anode, cathode}, 21'h100000)
		hard_src = 4'h0;
		rd_chk(OFS_HARD_FAULT_STATUS, 8'h02);
		`CHK(fault, 1'b1)
		clear_latch();
		`CHK({fault, bias_dac}, 10'h060)
		rd_chk(OFS_HARD_FAULT_STATUS, 8'h00);
		soft_src = 4'h1;
		pause();
		`CHK({fault, bias_dac}, 10'h060)
		rd_chk(OFS_SOFT_FAULT_STATUS, 8'h04);
		soft_src = 4'h0;
		disable_in = 1'b1;
		pause();
		`CHK({bias_dac, mod_dac}, 18'h0)
		disable_in = 1'b0;
		rd_chk(OFS_SOFT_FAULT_STATUS, 8'h00);
		$display("test faults done");
		master.frame({~ADDR_HI, OFS_TRANSMIT_CONTROL}, 1'b0, 8'h00, rd);
		pause();
		`CHK(bias_dac, 9'h060)
		master.frame({~ADDR_HI, OFS_BIAS_CODE}, 1'b1, 8'h00, rd);
		`CHK(rd, 8'hFF)
		rd_chk(5'h1F, 8'h00);
		wr(OFS_HARD_FAULT_STATUS, 8'hFF);
		rd_chk(OFS_HARD_FAULT_STATUS, 8'h00);
		$display("test refusals done");
		tally_and_finish();
	end

	// About fifty frames of a hundred cycles each are expected; this allows four times that.
	initial begin
		#200000;
		bad_count++;
		tally_and_finish();
	end
endmodule : tb_top

// *** rtl/ldc_core.sv ***
/*
 * Control registers, current code stepping, fault latching and serial slave of a laser driver.
 * Assumes every input is synchronous to mclk and the serial clock is slow against it.
 */
module ldc_core (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic chip_select,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic [1:0] address_level_select,
	input wire logic disable_in,
	input wire logic data_in_pos,
	input wire logic data_in_neg,
	input wire logic signal_detect,
	input wire logic [ldc_pkg::HARD_SRC_W-1:0] hard_fault_src,
	input wire logic [ldc_pkg::SOFT_SRC_W-1:0] soft_fault_src,
	output logic laser_anode_out,
	output logic laser_cathode_out,
	output logic [8:0] bias_dac,
	output logic [8:0] mod_dac,
	output logic [1:0] eq_boost,
	output logic [1:0] deemph_range,
	output logic [7:0] deemph_level,
	output logic [1:0] addr_hi,
	output logic fault
);
	import ldc_pkg::*;

	ldc_state_e state_r;
	logic scl_prev_r;
	logic [4:0] cnt_r;
	logic [15:0] sh_r;
	logic [7:0] rd_r;
	logic addr_done_r;
	logic [1:0] addr_hi_r;
	logic [7:0] ctrl_r, eq_r, deem_r, mask_r;
	logic [7:0] bias_hi_r, mod_hi_r, bias_lim_r, mod_lim_r, bias_step_r, mod_step_r;
	logic [HARD_SRC_W-1:0] hard_stat_r;
	logic sig_stat_r;
	logic bias_warn_r, mod_warn_r;
	logic [SOFT_SRC_W-1:0] soft_stat_r;
	logic dis_prev_r;
	logic fault_r;
	logic [8:0] bias_dac_r, mod_dac_r;
	logic anode_r, cathode_r, sda_out_r, sda_oe_n_r;
	logic [1:0] eq_boost_r, deemph_range_r;
	logic [7:0] deemph_level_r;

	logic scl_rise, match, commit, dis_toggle, out_on;
	logic [15:0] sh_nxt;
	logic [HARD_SRC_W-1:0] hard_hit;
	logic [7:0] rd_mux;

	ldc_step_if bias_if ();
	ldc_step_if mod_if ();

	ldc_step_unit u_bias_step (.sif(bias_if));
	ldc_step_unit u_mod_step (.sif(mod_if));

	assign scl_rise = scl & ~scl_prev_r;
	assign sh_nxt = {sh_r[14:0], sda_in};
	assign match = (sh_r[7:6] == addr_hi_r);
	assign commit = (state_r == ST_WDATA) && scl_rise && (cnt_r == FRAME_LAST - CNT_ONE);
	assign dis_toggle = dis_prev_r & ~disable_in;
	assign hard_hit = hard_fault_src & ~mask_r[HARD_SRC_W-1:0];
	assign out_on = ctrl_r[CTRL_TX_EN] & ~disable_in & ~fault_r;

	assign bias_if.step = sh_nxt[7:0];
	assign bias_if.limit = bias_lim_r;
	assign bias_if.cur = bias_hi_r;
	assign mod_if.step = sh_nxt[7:0];
	assign mod_if.limit = mod_lim_r;
	assign mod_if.cur = mod_hi_r;

	// Four-level select is caught once, on the first edge after reset release.
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			addr_done_r <= 1'b0;
			addr_hi_r <= 2'b00;
		end else if (!addr_done_r) begin
			addr_done_r <= 1'b1;
			addr_hi_r <= address_level_select;
		end
	end

	// After the eighth rise the header sits in sh_r[7:0]: address in bits 7:1, read flag in bit 0.
	always_comb begin
		case (sh_r[5:1])
			OFS_TRANSMIT_CONTROL: rd_mux = ctrl_r;
			OFS_HARD_FAULT_STATUS: rd_mux = {2'b00, sig_stat_r, 1'b0, hard_stat_r};
			OFS_SOFT_FAULT_STATUS: rd_mux = {2'b00, soft_stat_r, mod_warn_r, bias_warn_r};
			OFS_BIAS_CODE: rd_mux = bias_hi_r;
			OFS_MODULATION_CODE: rd_mux = mod_hi_r;
			OFS_MODULATION_CODE_LIMIT: rd_mux = mod_lim_r;
			OFS_BIAS_CODE_LIMIT: rd_mux = bias_lim_r;
			OFS_MODULATION_STEP: rd_mux = mod_step_r;
			OFS_BIAS_STEP: rd_mux = bias_step_r;
			OFS_FAULT_MASK: rd_mux = mask_r;
			OFS_DEEMPHASIS_SETTING: rd_mux = deem_r;
			OFS_INPUT_EQ_SETTING: rd_mux = eq_r;
			default: rd_mux = RST_ZERO;
		endcase
	end

	// Serial slave: bits are taken on scl rising edges, read data is driven on them too.
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= ST_IDLE;
			scl_prev_r <= 1'b0;
			cnt_r <= CNT_ZERO;
			sh_r <= 16'h0000;
			rd_r <= RST_ZERO;
			sda_out_r <= 1'b1;
			sda_oe_n_r <= 1'b1;
		end else begin
			scl_prev_r <= scl;
			if (!chip_select) begin
				state_r <= ST_IDLE;
				cnt_r <= CNT_ZERO;
				sda_out_r <= 1'b1;
				sda_oe_n_r <= 1'b1;
			end else begin
				case (state_r)
					ST_IDLE: begin
						state_r <= ST_HEAD;
						cnt_r <= CNT_ZERO;
					end
					ST_HEAD: begin
						if (scl_rise) begin
							sh_r <= sh_nxt;
							cnt_r <= cnt_r + CNT_ONE;
							if (cnt_r == HEAD_LAST - CNT_ONE) begin
								state_r <= sda_in ? ST_RDATA : ST_WDATA;
							end
						end
					end
					ST_RDATA: begin
						if (cnt_r == HEAD_LAST) begin
							rd_r <= match ? rd_mux : RST_ZERO;
							cnt_r <= cnt_r + CNT_ONE;
						end else if (scl_rise) begin
							// Open drain: only zeros are driven, ones are left to the pull-up.
							sda_out_r <= rd_r[7];
							sda_oe_n_r <= ~match | rd_r[7];
							rd_r <= {rd_r[6:0], 1'b0};
							cnt_r <= cnt_r + CNT_ONE;
							if (cnt_r == FRAME_LAST) begin
								state_r <= ST_DONE;
							end
						end
					end
					ST_WDATA: begin
						if (scl_rise) begin
							sh_r <= sh_nxt;
							cnt_r <= cnt_r + CNT_ONE;
							if (cnt_r == FRAME_LAST - CNT_ONE) begin
								state_r <= ST_DONE;
							end
						end
					end
					ST_DONE: begin
						if (scl_rise) begin
							sda_out_r <= 1'b1;
							sda_oe_n_r <= 1'b1;
						end
					end
					default: state_r <= ST_IDLE;
				endcase
			end
		end
	end

	// Plain setting registers; at commit sh_r holds the address in bits 14:8, the read flag in 7.
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_r <= RST_CTRL;
			eq_r <= RST_ZERO;
			deem_r <= RST_ZERO;
			mask_r <= RST_ZERO;
			bias_lim_r <= RST_LIMIT;
			mod_lim_r <= RST_LIMIT;
		end else if (commit && sh_r[14:13] == addr_hi_r) begin
			case (sh_r[12:8])
				OFS_TRANSMIT_CONTROL: ctrl_r <= sh_nxt[7:0];
				OFS_INPUT_EQ_SETTING: eq_r <= sh_nxt[7:0];
				OFS_DEEMPHASIS_SETTING: deem_r <= sh_nxt[7:0];
				OFS_FAULT_MASK: mask_r <= sh_nxt[7:0];
				OFS_BIAS_CODE_LIMIT: bias_lim_r <= sh_nxt[7:0];
				OFS_MODULATION_CODE_LIMIT: mod_lim_r <= sh_nxt[7:0];
				default: ;
			endcase
		end
	end

	// Bias code: direct setting, or stepped and clamped by the step unit.
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			bias_hi_r <= RST_CODE;
			bias_step_r <= RST_ZERO;
		end else if (commit && sh_r[14:13] == addr_hi_r) begin
			if (sh_r[12:8] == OFS_BIAS_CODE) begin
				bias_hi_r <= sh_nxt[7:0];
			end else if (sh_r[12:8] == OFS_BIAS_STEP) begin
				bias_step_r <= sh_nxt[7:0];
				bias_hi_r <= bias_if.nxt;
			end
		end
	end

	// Modulation code: same structure as the bias code.
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			mod_hi_r <= RST_CODE;
			mod_step_r <= RST_ZERO;
		end else if (commit && sh_r[14:13] == addr_hi_r) begin
			if (sh_r[12:8] == OFS_MODULATION_CODE) begin
				mod_hi_r <= sh_nxt[7:0];
			end else if (sh_r[12:8] == OFS_MODULATION_STEP) begin
				mod_step_r <= sh_nxt[7:0];
				mod_hi_r <= mod_if.nxt;
			end
		end
	end

	// Status and fault latch; a new event wins over the clear from a disable toggle.
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			dis_prev_r <= 1'b0;
			hard_stat_r <= '0;
			soft_stat_r <= '0;
			sig_stat_r <= 1'b0;
			bias_warn_r <= 1'b0;
			mod_warn_r <= 1'b0;
			fault_r <= 1'b0;
		end else begin
			dis_prev_r <= disable_in;
			sig_stat_r <= signal_detect;
			hard_stat_r <= (dis_toggle ? '0 : hard_stat_r) | hard_hit;
			soft_stat_r <= (dis_toggle ? '0 : soft_stat_r) | soft_fault_src;
			fault_r <= (fault_r & ~dis_toggle) | (|hard_hit);
			bias_warn_r <= (bias_warn_r & ~dis_toggle)
				| (commit && sh_r[12:8] == OFS_BIAS_STEP && sh_r[14:13] == addr_hi_r
				&& bias_if.over);
			mod_warn_r <= (mod_warn_r & ~dis_toggle)
				| (commit && sh_r[12:8] == OFS_MODULATION_STEP && sh_r[14:13] == addr_hi_r
				&& mod_if.over);
		end
	end

	// Analog control outputs; the limits cap the codes even after a direct write or a limit drop.
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			bias_dac_r <= DAC_OFF;
			mod_dac_r <= DAC_OFF;
			anode_r <= 1'b0;
			cathode_r <= 1'b0;
			eq_boost_r <= 2'b00;
			deemph_range_r <= 2'b00;
			deemph_level_r <= RST_ZERO;
		end else begin
			bias_dac_r <= out_on ? {(bias_hi_r > bias_lim_r) ? bias_lim_r : bias_hi_r,
				bias_step_r[STEP_LSB]} : DAC_OFF;
			mod_dac_r <= out_on ? {(mod_hi_r > mod_lim_r) ? mod_lim_r : mod_hi_r,
				mod_step_r[STEP_LSB]} : DAC_OFF;
			cathode_r <= out_on & (data_in_pos ^ ctrl_r[CTRL_POLARITY]);
			anode_r <= out_on & (data_in_neg ^ ctrl_r[CTRL_POLARITY]);
			eq_boost_r <= eq_r[1:0];
			deemph_range_r <= ctrl_r[CTRL_DE_HI:CTRL_DE_LO];
			deemph_level_r <= deem_r;
		end
	end

	assign sda_out = sda_out_r;
	assign sda_oe_n = sda_oe_n_r;
	assign bias_dac = bias_dac_r;
	assign mod_dac = mod_dac_r;
	assign laser_anode_out = anode_r;
	assign laser_cathode_out = cathode_r;
	assign eq_boost = eq_boost_r;
	assign deemph_range = deemph_range_r;
	assign deemph_level = deemph_level_r;
	assign addr_hi = addr_hi_r;
	assign fault = fault_r;

	a_bias_cap: assert property (@(posedge mclk) disable iff (sys_rst)
		bias_dac_r[8:1] <= $past(bias_lim_r)) else $error("bias code above limit");
	a_mod_cap: assert property (@(posedge mclk) disable iff (sys_rst)
		mod_dac_r[8:1] <= $past(mod_lim_r)) else $error("modulation code above limit");
	a_disable_off: assert property (@(posedge mclk) disable iff (sys_rst)
		disable_in |=> (bias_dac_r == DAC_OFF && mod_dac_r == DAC_OFF))
		else $error("currents on while disabled");
	a_fault_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		(fault_r && !dis_toggle) |=> fault_r) else $error("fault dropped without toggle");
	a_hard_kill: assert property (@(posedge mclk) disable iff (sys_rst)
		(|hard_hit) |=> fault_r ##1 (bias_dac_r == DAC_OFF && mod_dac_r == DAC_OFF))
		else $error("hard fault did not latch and disable");
	a_masked_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
		(!fault_r && hard_hit == '0) |=> !fault_r) else $error("fault without unmasked source");
	a_bias_clamp: assert property (@(posedge mclk) disable iff (sys_rst)
		(commit && sh_r[14:13] == addr_hi_r && sh_r[12:8] == OFS_BIAS_STEP && bias_if.over)
		|=> (bias_hi_r == $past(bias_lim_r) && bias_warn_r))
		else $error("bias clamp not applied");
	a_mod_floor: assert property (@(posedge mclk) disable iff (sys_rst)
		(commit && sh_r[14:13] == addr_hi_r && sh_r[12:8] == OFS_MODULATION_STEP
		&& ($signed({2'b00, mod_hi_r}) + $signed({{5{sh_nxt[4]}}, sh_nxt[4:0]})) < 0)
		|=> mod_hi_r == RST_ZERO) else $error("modulation code wrapped below zero");
	a_bias_floor: assert property (@(posedge mclk) disable iff (sys_rst)
		(commit && sh_r[14:13] == addr_hi_r && sh_r[12:8] == OFS_BIAS_STEP
		&& ($signed({2'b00, bias_hi_r}) + $signed({{5{sh_nxt[4]}}, sh_nxt[4:0]})) < 0)
		|=> bias_hi_r == RST_ZERO) else $error("bias code wrapped below zero");
	a_mod_clamp: assert property (@(posedge mclk) disable iff (sys_rst)
		(commit && sh_r[14:13] == addr_hi_r && sh_r[12:8] == OFS_MODULATION_STEP && mod_if.over)
		|=> (mod_hi_r == $past(mod_lim_r) && mod_warn_r))
		else $error("modulation clamp not applied");
	a_soft_record: assert property (@(posedge mclk) disable iff (sys_rst)
		(soft_fault_src != '0)
		|=> ((soft_stat_r & $past(soft_fault_src)) == $past(soft_fault_src)))
		else $error("soft fault not recorded");
	a_addr_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		addr_done_r |=> $stable(addr_hi_r)) else $error("address bits changed after capture");
endmodule : ldc_core

// *** rtl/ldc_pkg.sv ***
/*
 * Constants, register map and state codes for the laser driver control block.
 * Assumes the serial frame has already been reduced to synchronous samples of mclk.
 */
package ldc_pkg;
	localparam int FRAME_BITS = 16;
	localparam int HEAD_BITS = 8;
	localparam logic [4:0] FRAME_LAST = 5'h10;
	localparam logic [4:0] HEAD_LAST = 5'h08;
	localparam logic [4:0] CNT_ZERO = 5'h00;
	localparam logic [4:0] CNT_ONE = 5'h01;

	// Register indices inside the low five address bits of a frame.
	localparam logic [4:0] OFS_TRANSMIT_CONTROL = 5'h05;
	localparam logic [4:0] OFS_HARD_FAULT_STATUS = 5'h06;
	localparam logic [4:0] OFS_SOFT_FAULT_STATUS = 5'h07;
	localparam logic [4:0] OFS_BIAS_CODE = 5'h08;
	localparam logic [4:0] OFS_MODULATION_CODE = 5'h09;
	localparam logic [4:0] OFS_MODULATION_CODE_LIMIT = 5'h0A;
	localparam logic [4:0] OFS_BIAS_CODE_LIMIT = 5'h0B;
	localparam logic [4:0] OFS_MODULATION_STEP = 5'h0C;
	localparam logic [4:0] OFS_BIAS_STEP = 5'h0D;
	localparam logic [4:0] OFS_FAULT_MASK = 5'h0F;
	localparam logic [4:0] OFS_DEEMPHASIS_SETTING = 5'h10;
	localparam logic [4:0] OFS_INPUT_EQ_SETTING = 5'h11;

	// Field positions.
	localparam int CTRL_TX_EN = 0;
	localparam int CTRL_POLARITY = 1;
	localparam int CTRL_DE_LO = 3;
	localparam int CTRL_DE_HI = 4;
	localparam int STEP_LSB = 7;
	localparam int STEP_SIGN = 4;
	localparam int STAT1_SIGNAL = 5;
	localparam int STAT2_BIAS_WARN = 0;
	localparam int STAT2_MOD_WARN = 1;
	localparam int STAT2_SOFT_LO = 2;
	localparam int HARD_SRC_W = 4;
	localparam int SOFT_SRC_W = 4;

	// Reset values.
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_CODE = 8'h04;
	localparam logic [7:0] RST_LIMIT = 8'hFF;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [8:0] DAC_OFF = 9'h000;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_HEAD = 5'b00010,
		ST_WDATA = 5'b00100,
		ST_RDATA = 5'b01000,
		ST_DONE = 5'b10000
	} ldc_state_e;
endpackage : ldc_pkg

// *** rtl/ldc_step_if.sv ***
/*
 * Carries one current code, its limit and a signed step to the step unit and back.
 * Assumes the core drives the request side and the unit answers combinationally.
 */
interface ldc_step_if;
	logic [7:0] step;
	logic [7:0] limit;
	logic [7:0] cur;
	logic [7:0] nxt;
	logic over;

	modport core (output step, output limit, output cur, input nxt, input over);
	modport unit (input step, input limit, input cur, output nxt, output over);
endinterface : ldc_step_if

// *** rtl/ldc_step_unit.sv ***
/*
 * Adds a five-bit two's complement step to an eight-bit code with clamping.
 * Assumes the caller registers the result on the step write.
 */
module ldc_step_unit (
	ldc_step_if.unit sif
);
	import ldc_pkg::*;

	logic signed [9:0] sum;

	always_comb begin
		sum = $signed({2'b00, sif.cur}) + $signed({{5{sif.step[STEP_SIGN]}}, sif.step[4:0]});
		sif.over = 1'b0;
		if (sum < 0) begin
			// Going below zero stops at zero instead of wrapping.
			sif.nxt = RST_ZERO;
		end else if (sum > $signed({2'b00, sif.limit})) begin
			sif.nxt = sif.limit;
			sif.over = 1'b1;
		end else begin
			sif.nxt = sum[7:0];
		end
	end
endmodule : ldc_step_unit
